// ---- igm_pkg.sv ----
/*
 * shared constants for the gain / mute serial control slave.
 * assumes a single 50 MHz clock domain; the serial pins arrive asynchronously.
 */
package igm_pkg;

   // ****************************************
   // bus address and field layout
   // ****************************************
   localparam logic [7:0] CHIP_ADDR      = 8'hec;
   localparam int         GAIN_MSB       = 7;
   localparam int         GAIN_LSB       = 3;
   localparam int         MUTE_BIT       = 2;
   localparam int         LEFT_BIT       = 1;
   localparam int         RIGHT_BIT      = 0;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [4:0] GAIN_FLOOR     = 5'h00;
   localparam int         SYNC_STAGES    = 3;
   localparam logic [3:0] LAST_BIT       = 4'h7;

   // gain step in dB per 5-bit code, signed
   typedef logic signed [7:0] igm_db_t;

   function automatic igm_db_t igm_gain_db(input logic [4:0] code);
      igm_db_t t [32];
      t = '{-8'sd76, -8'sd62, -8'sd52, -8'sd44, -8'sd38, -8'sd34, -8'sd30, -8'sd27,
            -8'sd24, -8'sd21, -8'sd18, -8'sd16, -8'sd14, -8'sd12, -8'sd10, -8'sd8,
            -8'sd6,  -8'sd4,  -8'sd2,  8'sd0,   8'sd2,   8'sd4,   8'sd6,   8'sd8,
            8'sd10,  8'sd12,  8'sd13,  8'sd14,  8'sd15,  8'sd16,  8'sd17,  8'sd18};
      return t[code];
   endfunction

   typedef enum logic [1:0] {IGM_IDLE, IGM_BITS, IGM_ACK, IGM_SKIP} igm_state_t;

endpackage

// ---- igm_sync_if.sv ----
/*
 * carries the filtered serial pin levels and their events between modules.
 * assumes one clock drives both ends.
 */
`timescale 1ns/1ns
interface igm_sync_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   modport src (output scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
   modport dst (input  scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
endinterface

// ---- igm_pin_sync.sv ----
/*
 * three-stage pin synchroniser and bus event detector.
 * assumes scl and sda come from outside the clock domain.
 */
`timescale 1ns/1ns
module igm_pin_sync
   import igm_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   nrst,
   input  wire logic   scl_pin,
   input  wire logic   sda_pin,
   igm_sync_if.src     ev
);
   logic [2:0] scl_sh;
   logic [2:0] sda_sh;
   logic       scl_q;
   logic       sda_q;
   logic [2:0] next_scl_sh;
   logic [2:0] next_sda_sh;
   logic       next_scl_q;
   logic       next_sda_q;

   // ****************************************
   // filtered levels: stage 1 feeds only stage 2
   // ****************************************
   always_comb begin
      next_scl_sh = {scl_sh[1:0], scl_pin};
      next_sda_sh = {sda_sh[1:0], sda_pin};
      next_scl_q  = (scl_sh[1] == scl_sh[2]) ? scl_sh[2] : scl_q;
      next_sda_q  = (sda_sh[1] == sda_sh[2]) ? sda_sh[2] : sda_q;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         scl_sh <= 3'h7;
         sda_sh <= 3'h7;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end else begin
         scl_sh <= next_scl_sh;
         sda_sh <= next_sda_sh;
         scl_q  <= next_scl_q;
         sda_q  <= next_sda_q;
      end
   end

   // ****************************************
   // events
   // ****************************************
   assign ev.scl        = scl_q;
   assign ev.sda        = sda_q;
   assign ev.scl_rise   = next_scl_q & ~scl_q;
   assign ev.scl_fall   = ~next_scl_q & scl_q;
   assign ev.start_seen = scl_q & next_scl_q & sda_q & ~next_sda_q; // RULE1
   assign ev.stop_seen  = scl_q & next_scl_q & ~sda_q & next_sda_q; // RULE10
endmodule

// ---- igm_ctrl.sv ----
/*
 * write-only serial control slave holding gain, mute and channel enables.
 * assumes an external bus master on scl/sda with an sda pull-up.
 */
`timescale 1ns/1ns
// Overview of operation
// RULE1 - sda falling while scl high begins a transfer
// RULE2 - address byte must equal 11101100 for the slave to take part
// RULE3 - master sends address msb first, stable while scl high
// RULE4 - each bit is sampled on the rising edge of scl
// RULE5 - matched address is acknowledged by holding sda low through the ninth pulse
// RULE6 - master abandons the transfer when the address is not acknowledged; the bench host sends one more byte, then restarts
// RULE7 - master sends eight data bits msb first, valid while scl high
// RULE8 - slave acknowledges each data byte by pulling sda low
// RULE9 - any number of data bytes are accepted and acknowledged until stop
// RULE10 - sda rising while scl high ends the transfer; slave waits for start
// RULE11 - master keeps sda high while the bus is idle
// RULE12 - scl is input only; slave only pulls sda low or releases it
// RULE13 - master keeps scl at or below 400 kHz
// RULE14 - data byte stores gain in bits 7..3, mute, left, right enables
// RULE15 - gain codes 0 to 15 map to -76 up to -8 dB
// RULE16 - gain codes 16 to 31 map to -6 up to +18 dB
// RULE17 - a channel whose enable is 0 is disabled, output high impedance
// RULE18 - mute forces the lowest gain; stored code remains for later
// RULE19 - unmatched address: no acknowledge, ignore bytes until next start
module igm_ctrl
   import igm_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic          scl_pin,
   input  wire logic          sda_pin,
   output logic               sda_out,
   output logic               sda_oe,
   output logic [7:0]         gain_and_channel_control,
   output logic [4:0]         gain_code,
   output igm_pkg::igm_db_t   gain_db,
   output logic               mute_on,
   output logic               left_channel_on,
   output logic               right_channel_on,
   output logic               left_hiz,
   output logic               right_hiz,
   output logic               byte_written
);
   igm_sync_if ev ();

   igm_pin_sync u_sync (
      .clk     (clk),
      .nrst    (nrst),
      .scl_pin (scl_pin),
      .sda_pin (sda_pin),
      .ev      (ev)
   );

   igm_state_t state;
   igm_state_t next_state;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [3:0] bitcnt;
   logic [3:0] next_bitcnt;
   logic       is_addr;
   logic       next_is_addr;
   logic       ack_pull;
   logic       next_ack_pull;
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic       wr_pulse;
   logic       next_wr_pulse;

   // ****************************************
   // protocol engine
   // ****************************************
   always_comb begin
      next_state    = state;
      next_shreg    = shreg;
      next_bitcnt   = bitcnt;
      next_is_addr  = is_addr;
      next_ack_pull = ack_pull;
      next_ctrl     = ctrl;
      next_wr_pulse = 1'b0;
      if (ev.start_seen) begin
         next_state    = IGM_BITS; // RULE1
         next_bitcnt   = 4'h0;
         next_is_addr  = 1'b1;
         next_ack_pull = 1'b0;
      end else if (ev.stop_seen) begin
         next_state    = IGM_IDLE; // RULE10
         next_ack_pull = 1'b0;
      end else begin
         unique case (state)
            IGM_IDLE: begin
               next_ack_pull = 1'b0;
            end
            IGM_BITS: begin
               if (ev.scl_rise) begin
                  next_shreg  = {shreg[6:0], ev.sda}; // RULE4
                  next_bitcnt = bitcnt + 4'h1;
               end
               // ack drive starts after the eighth bit's falling edge
               if (ev.scl_fall && bitcnt == LAST_BIT + 4'h1) begin
                  if (is_addr && shreg != CHIP_ADDR) begin // RULE2
                     next_state = IGM_SKIP; // RULE19
                  end else begin
                     next_state    = IGM_ACK;
                     next_ack_pull = 1'b1; // RULE5 RULE8
                     if (!is_addr) begin
                        next_ctrl     = shreg; // RULE14
                        next_wr_pulse = 1'b1;
                     end
                  end
               end
            end
            IGM_ACK: begin
               // release only after the ack pulse falls, so low covers the whole pulse
               if (ev.scl_fall) begin
                  next_ack_pull = 1'b0;
                  next_state    = IGM_BITS; // RULE9
                  next_bitcnt   = 4'h0;
                  next_is_addr  = 1'b0; // RULE2
               end
            end
            IGM_SKIP: begin
               next_ack_pull = 1'b0; // RULE19
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state    <= IGM_IDLE;
         shreg    <= 8'h00;
         bitcnt   <= 4'h0;
         is_addr  <= 1'b0;
         ack_pull <= 1'b0;
         ctrl     <= CTRL_RESET;
         wr_pulse <= 1'b0;
      end else begin
         state    <= next_state;
         shreg    <= next_shreg;
         bitcnt   <= next_bitcnt;
         is_addr  <= next_is_addr;
         ack_pull <= next_ack_pull;
         ctrl     <= next_ctrl;
         wr_pulse <= next_wr_pulse;
      end
   end

   // ****************************************
   // decoded outputs, all registered
   // ****************************************
   logic [4:0] next_gain_code;
   igm_db_t    next_gain_db;

   always_comb begin
      next_gain_code = ctrl[GAIN_MSB:GAIN_LSB];
      // stored code survives mute; only the effective gain drops
      next_gain_db = igm_gain_db(ctrl[MUTE_BIT] ? GAIN_FLOOR : ctrl[GAIN_MSB:GAIN_LSB]); // RULE15 RULE16 RULE18
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sda_out                  <= 1'b0;
         sda_oe                   <= 1'b0;
         gain_and_channel_control <= CTRL_RESET;
         gain_code                <= CTRL_RESET[GAIN_MSB:GAIN_LSB];
         gain_db                  <= igm_gain_db(GAIN_FLOOR);
         mute_on                  <= 1'b0;
         left_channel_on          <= 1'b0;
         right_channel_on         <= 1'b0;
         left_hiz                 <= 1'b1;
         right_hiz                <= 1'b1;
         byte_written             <= 1'b0;
      end else begin
         sda_out                  <= 1'b0; // RULE12
         sda_oe                   <= next_ack_pull; // RULE12
         gain_and_channel_control <= ctrl;
         gain_code                <= next_gain_code;
         gain_db                  <= next_gain_db;
         mute_on                  <= ctrl[MUTE_BIT];
         left_channel_on          <= ctrl[LEFT_BIT];
         right_channel_on         <= ctrl[RIGHT_BIT];
         left_hiz                 <= ~ctrl[LEFT_BIT]; // RULE17
         right_hiz                <= ~ctrl[RIGHT_BIT]; // RULE17
         byte_written             <= wr_pulse;
      end
   end
endmodule

// ---- igm_ctrl_assertions.sv ----
/*
 * concurrent checks on the serial control slave's ports.
 * assumes clk is the only domain and nrst is synchronous, active low.
 */
`timescale 1ns/1ns
module igm_ctrl_assertions
   import igm_pkg::*;
(
   input wire logic             clk,
   input wire logic             nrst,
   input wire logic             scl_pin,
   input wire logic             sda_pin,
   input wire logic             sda_out,
   input wire logic             sda_oe,
   input wire logic [7:0]       gain_and_channel_control,
   input wire logic [4:0]       gain_code,
   input wire igm_pkg::igm_db_t gain_db,
   input wire logic             mute_on,
   input wire logic             left_channel_on,
   input wire logic             right_channel_on,
   input wire logic             left_hiz,
   input wire logic             right_hiz,
   input wire logic             byte_written
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_ack_begin;
      $rose(sda_oe);
   endsequence
   sequence s_ack_body;
      sda_oe[*8];
   endsequence
   a_open_drain: assert property (sda_out == 1'b0) else $error("sda driven high");
   a_ack_hold: assert property (s_ack_begin |-> s_ack_body) else $error("ack too short");
   a_ack_scl_low: assert property (s_ack_begin |-> !scl_pin) else $error("ack began with scl high");
   a_ack_whole: assert property (sda_oe && scl_pin |=> sda_oe || !scl_pin) else $error("ack dropped in pulse");
   a_byte_acked: assert property (byte_written |-> sda_oe) else $error("byte stored without ack");
   a_pulse_once: assert property (byte_written |=> !byte_written) else $error("write pulse too long");
   // control and the write pulse leave the same output edge, so they must coincide
   a_ctrl_written: assert property ($changed(gain_and_channel_control) |-> byte_written)
      else $error("control changed without write");
   a_field_split: assert property ({gain_code, mute_on, left_channel_on, right_channel_on}
      == gain_and_channel_control) else $error("fields do not follow control");
   a_mute_floor: assert property (mute_on |-> gain_db == -8'sd76) else $error("mute not at floor");
   a_chan_hiz: assert property ({left_hiz, right_hiz} == ~{left_channel_on, right_channel_on})
      else $error("hi-z does not follow enable");
endmodule
bind igm_ctrl igm_ctrl_assertions u_chk (.clk(clk), .nrst(nrst), .scl_pin(scl_pin), .sda_pin(sda_pin),
   .sda_out(sda_out), .sda_oe(sda_oe), .gain_and_channel_control(gain_and_channel_control),
   .gain_code(gain_code), .gain_db(gain_db), .mute_on(mute_on), .left_channel_on(left_channel_on),
   .right_channel_on(right_channel_on), .left_hiz(left_hiz), .right_hiz(right_hiz),
   .byte_written(byte_written));

// ---- igm_host_model.sv ----
/*
 * behavioural bus master that writes bytes to the slave.
 * assumes calls start on a falling clk edge; sda has a pull-up outside.
 */
`timescale 1ns/1ns
module igm_host_model (
   output logic      scl,
   output logic      sda,
   input  wire logic sda_bus
);
   // quarter scl period; 2.56 us period stays just under 400 kHz
   localparam int Q = 640;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic bus_start();
      sda = 1'b1;
      #Q scl = 1'b1;
      #Q sda = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic bus_stop();
      sda = 1'b0;
      #Q scl = 1'b1;
      #Q sda = 1'b1;
      #Q;
   endtask
   // sda only moves mid-low so it is stable through every high phase
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda = b[i];
         #Q scl = 1'b1;
         #(2*Q) scl = 1'b0;
         #Q;
      end
      sda = 1'b1;
      #Q scl = 1'b1;
      #Q ack = !sda_bus;
      #Q scl = 1'b0;
      #Q;
   endtask
endmodule

// ---- tb.sv ----
/*
 * self-checking bench for the serial gain / mute control slave.
 * assumes the host model drives the bus and the wire has a pull-up.
 */
`timescale 1ns/1ns
module tb;
   import igm_pkg::*;
   logic        clk, nrst, scl, host_sda, sda_wire, sda_out, sda_oe, byte_written, ack;
   logic        mute_on, left_channel_on, right_channel_on, left_hiz, right_hiz;
   logic [7:0]  ctrl, b, e;
   logic [4:0]  gain_code;
   igm_db_t     gain_db;
   logic [7:0]  exp_q[$];
   int          n_errors, checks;
   logic [31:0] seed = 32'd88430;
   int db_tab[32] = '{-76, -62, -52, -44, -38, -34, -30, -27, -24, -21, -18, -16, -14, -12, -10, -8,
                      -6, -4, -2, 0, 2, 4, 6, 8, 10, 12, 13, 14, 15, 16, 17, 18};
   // pull-up: the wire is low only while someone pulls it
   assign sda_wire = host_sda & !(sda_oe & !sda_out);
   igm_host_model u_host (.scl(scl), .sda(host_sda), .sda_bus(sda_wire));
   igm_ctrl u_dut (.clk(clk), .nrst(nrst), .scl_pin(scl), .sda_pin(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .gain_and_channel_control(ctrl), .gain_code(gain_code), .gain_db(gain_db),
      .mute_on(mute_on), .left_channel_on(left_channel_on), .right_channel_on(right_channel_on),
      .left_hiz(left_hiz), .right_hiz(right_hiz), .byte_written(byte_written));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ****************************************
   // clock, monitor, stimulus
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // empty queue: expect the inverse so a stray write fails
   always @(negedge clk) begin
      if (nrst && byte_written === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : ~ctrl;
         chk(ctrl, e, "control byte");
         chk(gain_db, e[2] ? 8'hb4 : 8'(db_tab[e[7:3]]), "gain db");
         chk({gain_code, mute_on, left_channel_on, right_channel_on}, e, "fields");
         chk({6'h00, left_hiz, right_hiz}, {6'h00, ~e[1:0]}, "hi-z");
      end
   end
   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      $display("MISMATCH %0t run did not finish", $time);
      report_and_stop();
   end
   initial begin
      nrst = 1'b0;
      n_errors = 0;
      checks = 0;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      u_host.bus_start();
      u_host.send_byte(CHIP_ADDR, ack);
      chk({7'h00, ack}, 8'h01, "address ack");
      for (int i = 0; i < 32; i++) begin
         b = {i[4:0], i[2:0]};
         exp_q.push_back(b);
         u_host.send_byte(b, ack);
         chk({7'h00, ack}, 8'h01, "data ack");
      end
      u_host.bus_stop();
      $display("test gain sweep done");
      b = xs();
      if (b == CHIP_ADDR)
         b = b ^ 8'h01;
      u_host.bus_start();
      u_host.send_byte(b, ack);
      chk({7'h00, ack}, 8'h00, "foreign address ack");
      u_host.send_byte(xs(), ack);
      chk({7'h00, ack}, 8'h00, "foreign data ack");
      chk(ctrl, 8'hff, "control kept");
      $display("test foreign address done");
      b = xs();
      u_host.bus_start();
      u_host.send_byte(CHIP_ADDR, ack);
      chk({7'h00, ack}, 8'h01, "restart ack");
      exp_q.push_back(b);
      u_host.send_byte(b, ack);
      chk({7'h00, ack}, 8'h01, "restart data ack");
      u_host.bus_stop();
      chk(8'(exp_q.size()), 8'h00, "pending writes");
      $display("test repeated start done");
      report_and_stop();
   end
endmodule
